/* src/esc_event_regs.sv */
// Event status and capture enable register bank with host signalling.
`timescale 1ns/1ps
module esc_event_regs #(
   parameter bit HAS_SENSOR_SUPPLY = 1'b1,
   parameter int unsigned DELAY_CYC = esc_pkg::ESC_EVENT_DELAY_CYC
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic ce,
   input wire esc_pkg::esc_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   input wire esc_pkg::esc_evt_t evt,
   input wire esc_pkg::esc_cap_en_t cap_en,
   input wire logic local_input,
   input wire logic bus_active,
   input wire logic transceiver_offline,
   input wire logic controller_supply_on,
   input wire logic reset_pin_low,
   output logic event_pending,
   output logic rxd
);
   localparam logic [7:0] SUP_MASK = HAS_SENSOR_SUPPLY ?
      esc_pkg::ESC_SUP_MASK_FULL : esc_pkg::ESC_SUP_MASK_BASE;

   typedef struct packed {
      logic [7:0] sys_en;
      logic [7:0] rdata;
      logic input_prev;
      logic input_seen;
   } esc_regs_state_t;

   esc_regs_state_t state_r;
   esc_regs_state_t state_nxt;

   logic [7:0] sys_flags;
   logic [7:0] sup_flags;
   logic [7:0] trx_flags;
   logic [7:0] wk_flags;
   logic [7:0] sys_set;
   logic [7:0] sup_set;
   logic [7:0] trx_set;
   logic [7:0] wk_set;
   logic [7:0] trx_hw_clr;
   logic [7:0] sys_w1c;
   logic [7:0] sup_w1c;
   logic [7:0] trx_w1c;
   logic [7:0] wk_w1c;
   logic [7:0] summary;
   logic [7:0] rd_mux;
   logic [3:0] cleared;
   logic any_cleared;
   logic input_rise;
   logic input_fall;
   logic timer_busy;
   logic signal_ok;

   // Host writes of 1 hit only implemented bits of the addressed register.
   always_comb
   begin
      sys_w1c = 8'h00;
      sup_w1c = 8'h00;
      trx_w1c = 8'h00;
      wk_w1c = 8'h00;
      if (reg_req.wr)
      begin
         unique case (reg_req.addr)
            esc_pkg::ESC_ADDR_SYS:
               sys_w1c = reg_req.wdata & esc_pkg::ESC_SYS_MASK;
            esc_pkg::ESC_ADDR_SUP:
               sup_w1c = reg_req.wdata & SUP_MASK;
            esc_pkg::ESC_ADDR_TRX:
               trx_w1c = reg_req.wdata & esc_pkg::ESC_TRX_MASK;
            esc_pkg::ESC_ADDR_WAKE:
               wk_w1c = reg_req.wdata & esc_pkg::ESC_WAKE_MASK;
            default:
               sys_w1c = 8'h00;
         endcase
      end
   end

   // The first sample after reset only primes the edge detector.
   assign input_rise = state_r.input_seen && !state_r.input_prev &&
      local_input;
   assign input_fall = state_r.input_seen && state_r.input_prev &&
      !local_input;

   always_comb
   begin
      sys_set = 8'h00;
      sys_set[esc_pkg::ESC_SYS_COLD] = evt.cold_start;
      sys_set[esc_pkg::ESC_SYS_THERM] = evt.thermal_warn &&
         state_r.sys_en[esc_pkg::ESC_SYS_THERM];
      sys_set[esc_pkg::ESC_SYS_SERIAL] = evt.serial_fail &&
         state_r.sys_en[esc_pkg::ESC_SYS_SERIAL];
      sys_set[esc_pkg::ESC_SYS_WDOG] = evt.watchdog_fail;

      sup_set = 8'h00;
      sup_set[esc_pkg::ESC_SUP_OVER] = HAS_SENSOR_SUPPLY &&
         evt.sensor_over && cap_en.sensor_over;
      sup_set[esc_pkg::ESC_SUP_UNDER] = HAS_SENSOR_SUPPLY &&
         evt.sensor_under && cap_en.sensor_under;
      sup_set[esc_pkg::ESC_SUP_CTRL] = evt.ctrl_supply_under &&
         cap_en.ctrl_supply_under;

      trx_set = 8'h00;
      trx_set[esc_pkg::ESC_TRX_SILENCE] = evt.bus_silence &&
         cap_en.bus_silence;
      trx_set[esc_pkg::ESC_TRX_SHUTOFF] = evt.transceiver_shutoff &&
         cap_en.transceiver_shutoff;
      trx_set[esc_pkg::ESC_TRX_RESUME] = evt.bus_resume &&
         transceiver_offline && cap_en.bus_resume;

      wk_set = 8'h00;
      wk_set[esc_pkg::ESC_WK_RISE] = input_rise &&
         cap_en.input_rise;
      wk_set[esc_pkg::ESC_WK_FALL] = input_fall &&
         cap_en.input_fall;

      // Bus activity wipes the silence flag unless a silence event with its capture enabled is reported now.
      trx_hw_clr = 8'h00;
      trx_hw_clr[esc_pkg::ESC_TRX_SILENCE] = bus_active;
   end

   esc_flag_bank #(.W(8), .MASK(esc_pkg::ESC_SYS_MASK)) u_sys (
      .clock(clock),
      .rst_b(rst_b),
      .ce(ce),
      .set(sys_set),
      .hw_clr(8'h00),
      .w1c(sys_w1c),
      .flags(sys_flags),
      .cleared(cleared[0])
   );

   esc_flag_bank #(.W(8), .MASK(SUP_MASK)) u_sup (
      .clock(clock),
      .rst_b(rst_b),
      .ce(ce),
      .set(sup_set),
      .hw_clr(8'h00),
      .w1c(sup_w1c),
      .flags(sup_flags),
      .cleared(cleared[1])
   );

   esc_flag_bank #(.W(8), .MASK(esc_pkg::ESC_TRX_MASK)) u_trx (
      .clock(clock),
      .rst_b(rst_b),
      .ce(ce),
      .set(trx_set),
      .hw_clr(trx_hw_clr),
      .w1c(trx_w1c),
      .flags(trx_flags),
      .cleared(cleared[2])
   );

   esc_flag_bank #(.W(8), .MASK(esc_pkg::ESC_WAKE_MASK)) u_wake (
      .clock(clock),
      .rst_b(rst_b),
      .ce(ce),
      .set(wk_set),
      .hw_clr(8'h00),
      .w1c(wk_w1c),
      .flags(wk_flags),
      .cleared(cleared[3])
   );

   always_comb
   begin
      summary = 8'h00;
      summary[esc_pkg::ESC_SUM_WAKE] = |wk_flags;
      summary[esc_pkg::ESC_SUM_TRX] = |trx_flags;
      summary[esc_pkg::ESC_SUM_SUP] = |sup_flags;
      summary[esc_pkg::ESC_SUM_SYS] = |sys_flags;
   end

   assign any_cleared = |cleared;
   assign event_pending = |summary;
   assign signal_ok = transceiver_offline && controller_supply_on;

   // Reserved bits come back as zero because flags and enables are masked.
   always_comb
   begin
      unique case (reg_req.addr)
         esc_pkg::ESC_ADDR_SYS_EN: rd_mux = state_r.sys_en;
         esc_pkg::ESC_ADDR_GLOBAL: rd_mux = summary;
         esc_pkg::ESC_ADDR_SYS: rd_mux = sys_flags;
         esc_pkg::ESC_ADDR_SUP: rd_mux = sup_flags;
         esc_pkg::ESC_ADDR_TRX: rd_mux = trx_flags;
         esc_pkg::ESC_ADDR_WAKE: rd_mux = wk_flags;
         default: rd_mux = 8'h00;
      endcase
   end

   always_comb
   begin
      state_nxt = state_r;
      state_nxt.input_prev = local_input;
      state_nxt.input_seen = 1'b1;
      if (reg_req.rd)
         state_nxt.rdata = rd_mux;
      if (reg_req.wr && reg_req.addr == esc_pkg::ESC_ADDR_SYS_EN)
         state_nxt.sys_en = reg_req.wdata & esc_pkg::ESC_EN_MASK;
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_r.sys_en <= esc_pkg::ESC_EN_RST;
         state_r.rdata <= 8'h00;
         state_r.input_prev <= 1'b0;
         state_r.input_seen <= 1'b0;
      end
      else if (ce)
         state_r <= state_nxt;
   end

   assign reg_rdata = state_r.rdata;

   // The timer only delays signalling; flags keep capturing while it runs.
   esc_event_delay #(.DELAY_CYC(DELAY_CYC)) u_delay (
      .clock(clock),
      .rst_b(rst_b),
      .ce(ce),
      .start(any_cleared),
      .stop(reset_pin_low),
      .pending(event_pending),
      .signal_ok(signal_ok),
      .busy(timer_busy),
      .rxd(rxd)
   );

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   sequence host_rd_global_s;
      ce && reg_req.rd && reg_req.addr == esc_pkg::ESC_ADDR_GLOBAL;
   endsequence

   sequence rise_s;
      ce && !local_input && state_r.input_seen ##1 ce && local_input;
   endsequence

   sequence fall_s;
      ce && local_input && state_r.input_seen ##1 ce && !local_input;
   endsequence

   AST_W1C_CLEARS:
   assert property (ce && sys_w1c[esc_pkg::ESC_SYS_WDOG] &&
      !sys_set[esc_pkg::ESC_SYS_WDOG] |=> !sys_flags[esc_pkg::ESC_SYS_WDOG])
      else $error("Write of one did not clear watchdog flag");

   AST_W0_KEEPS:
   assert property (ce && reg_req.wr && reg_req.addr == esc_pkg::ESC_ADDR_SYS
      && !reg_req.wdata[esc_pkg::ESC_SYS_COLD] &&
      sys_flags[esc_pkg::ESC_SYS_COLD] |=> sys_flags[esc_pkg::ESC_SYS_COLD])
      else $error("Write of zero changed cold start flag");

   AST_SUM_WAKE:
   assert property (host_rd_global_s |=> reg_rdata[7:4] == 4'h0 &&
      reg_rdata[esc_pkg::ESC_SUM_WAKE] == ($past(wk_flags) != 8'h00))
      else $error("Summary local input bit or reserved bits wrong");

   AST_SUM_TRX:
   assert property (host_rd_global_s |=>
      reg_rdata[esc_pkg::ESC_SUM_TRX] == ($past(trx_flags) != 8'h00))
      else $error("Summary transceiver bit wrong");

   AST_SUM_SUP:
   assert property (host_rd_global_s |=>
      reg_rdata[esc_pkg::ESC_SUM_SUP] == ($past(sup_flags) != 8'h00))
      else $error("Summary supply bit wrong");

   AST_SUM_SYS:
   assert property (host_rd_global_s |=>
      reg_rdata[esc_pkg::ESC_SUM_SYS] == ($past(sys_flags) != 8'h00))
      else $error("Summary system bit wrong");

   AST_COLD_ALWAYS:
   assert property (ce && evt.cold_start |=>
      sys_flags[esc_pkg::ESC_SYS_COLD] && summary[esc_pkg::ESC_SUM_SYS])
      else $error("Cold start event not captured");

   AST_THERM_GATED:
   assert property (ce && evt.thermal_warn |=>
      sys_flags[esc_pkg::ESC_SYS_THERM] ==
      ($past(state_r.sys_en[esc_pkg::ESC_SYS_THERM]) ||
      $past(sys_flags[esc_pkg::ESC_SYS_THERM]) &&
      !$past(sys_w1c[esc_pkg::ESC_SYS_THERM])))
      else $error("Thermal warning capture ignores its enable");

   AST_SILENCE_ACTIVE:
   assert property (ce && bus_active && !trx_set[esc_pkg::ESC_TRX_SILENCE]
      |=> !trx_flags[esc_pkg::ESC_TRX_SILENCE])
      else $error("Silence flag set while bus active");

   AST_RISE_CAPTURE:
   assert property (rise_s ##0 cap_en.input_rise |=>
      wk_flags[esc_pkg::ESC_WK_RISE])
      else $error("Rising edge of local input not captured");

   AST_FALL_CAPTURE:
   assert property (fall_s ##0 cap_en.input_fall |=>
      wk_flags[esc_pkg::ESC_WK_FALL])
      else $error("Falling edge of local input not captured");

   AST_SET_WINS:
   assert property (ce && sys_set[esc_pkg::ESC_SYS_WDOG] &&
      sys_w1c[esc_pkg::ESC_SYS_WDOG] |=>
      sys_flags[esc_pkg::ESC_SYS_WDOG])
      else $error("Same-cycle clear beat a new event");

   AST_PENDING_LOW:
   assert property (ce && signal_ok && event_pending && !timer_busy &&
      !any_cleared && !reset_pin_low |=> !rxd)
      else $error("Pending event not signalled low");

   AST_CLEAR_RELEASES:
   assert property (ce && any_cleared && !reset_pin_low |=>
      rxd && timer_busy)
      else $error("Clearing a flag did not release line and start timer");

endmodule : esc_event_regs

/* src/esc_pkg.sv */
// Package with register map, field layout, reset values and carriers.
package esc_pkg;

   localparam int ESC_AW = 7;
   localparam int ESC_DW = 8;

   localparam logic [6:0] ESC_ADDR_SYS_EN = 7'h04;
   localparam logic [6:0] ESC_ADDR_GLOBAL = 7'h60;
   localparam logic [6:0] ESC_ADDR_SYS = 7'h61;
   localparam logic [6:0] ESC_ADDR_SUP = 7'h62;
   localparam logic [6:0] ESC_ADDR_TRX = 7'h63;
   localparam logic [6:0] ESC_ADDR_WAKE = 7'h64;

   localparam int ESC_SYS_COLD = 4;
   localparam int ESC_SYS_THERM = 2;
   localparam int ESC_SYS_SERIAL = 1;
   localparam int ESC_SYS_WDOG = 0;
   localparam int ESC_SUP_OVER = 2;
   localparam int ESC_SUP_UNDER = 1;
   localparam int ESC_SUP_CTRL = 0;
   localparam int ESC_TRX_SILENCE = 4;
   localparam int ESC_TRX_SHUTOFF = 1;
   localparam int ESC_TRX_RESUME = 0;
   localparam int ESC_WK_RISE = 1;
   localparam int ESC_WK_FALL = 0;
   localparam int ESC_SUM_WAKE = 3;
   localparam int ESC_SUM_TRX = 2;
   localparam int ESC_SUM_SUP = 1;
   localparam int ESC_SUM_SYS = 0;

   localparam logic [7:0] ESC_SYS_MASK = 8'h17;
   localparam logic [7:0] ESC_SUP_MASK_FULL = 8'h07;
   localparam logic [7:0] ESC_SUP_MASK_BASE = 8'h01;
   localparam logic [7:0] ESC_TRX_MASK = 8'h13;
   localparam logic [7:0] ESC_WAKE_MASK = 8'h03;
   localparam logic [7:0] ESC_EN_MASK = 8'h06;

   localparam logic [7:0] ESC_FLAG_RST = 8'h00;
   localparam logic [7:0] ESC_EN_RST = 8'h00;
   localparam logic ESC_RXD_RST = 1'b1;

   localparam int ESC_CLK_MHZ = 100;
   localparam int ESC_EVENT_DELAY_US = 1000;
   localparam int ESC_EVENT_DELAY_CYC = ESC_EVENT_DELAY_US * ESC_CLK_MHZ;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } esc_reg_req_t;

   typedef struct packed {
      logic cold_start;
      logic thermal_warn;
      logic serial_fail;
      logic watchdog_fail;
      logic sensor_over;
      logic sensor_under;
      logic ctrl_supply_under;
      logic bus_silence;
      logic transceiver_shutoff;
      logic bus_resume;
   } esc_evt_t;

   typedef struct packed {
      logic sensor_over;
      logic sensor_under;
      logic ctrl_supply_under;
      logic bus_silence;
      logic transceiver_shutoff;
      logic bus_resume;
      logic input_rise;
      logic input_fall;
   } esc_cap_en_t;

endpackage : esc_pkg

/* src/esc_flag_bank.sv */
// Sticky write-one-to-clear flag register with set priority.
`timescale 1ns/1ps
module esc_flag_bank #(
   parameter int W = 8,
   parameter logic [W-1:0] MASK = '1
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic [W-1:0] set,
   input wire logic [W-1:0] hw_clr,
   input wire logic [W-1:0] w1c,
   output logic [W-1:0] flags,
   output logic cleared
);
   typedef struct packed {
      logic [W-1:0] flags;
   } esc_bank_state_t;

   esc_bank_state_t state_r;
   esc_bank_state_t state_nxt;
   logic [W-1:0] bit_nxt;

   // A set in the same cycle as a clear keeps the flag, so no event is lost.
   for (genvar i = 0; i < W; i++)
   begin : g_bit
      assign bit_nxt[i] = MASK[i] &
         (set[i] | (state_r.flags[i] & ~w1c[i] & ~hw_clr[i]));
   end

   always_comb
   begin
      state_nxt.flags = bit_nxt;
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         state_r.flags <= W'(esc_pkg::ESC_FLAG_RST);
      else if (ce)
         state_r <= state_nxt;
   end

   assign flags = state_r.flags;
   assign cleared = |(state_r.flags & w1c & ~set);

endmodule : esc_flag_bank

/* src/esc_event_delay.sv */
// Event delay timer and receive-data signalling of pending events.
`timescale 1ns/1ps
module esc_event_delay #(
   parameter int unsigned DELAY_CYC = 100000
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic start,
   input wire logic stop,
   input wire logic pending,
   input wire logic signal_ok,
   output logic busy,
   output logic rxd
);
   localparam int CW = $clog2(DELAY_CYC + 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic running;
      logic rxd;
   } esc_dly_state_t;

   esc_dly_state_t state_r;
   esc_dly_state_t state_nxt;

   always_comb
   begin
      state_nxt = state_r;
      if (stop)
         state_nxt.running = 1'b0;
      else if (start)
      begin
         state_nxt.running = 1'b1;
         state_nxt.cnt = CW'(DELAY_CYC - 1);
      end
      else if (state_r.running)
      begin
         if (state_r.cnt == '0)
            state_nxt.running = 1'b0;
         else
            state_nxt.cnt = state_r.cnt - CW'(1);
      end
      // Line is held high while the timer runs; it is low only while an event is pending, signal_ok holds and the timer has expired or is stopped.
      state_nxt.rxd = !(signal_ok && pending && !state_nxt.running);
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_r.cnt <= '0;
         state_r.running <= 1'b0;
         state_r.rxd <= esc_pkg::ESC_RXD_RST;
      end
      else if (ce)
         state_r <= state_nxt;
   end

   assign busy = state_r.running;
   assign rxd = state_r.rxd;

endmodule : esc_event_delay

/* verif/esc_host_model.sv */
// Host model that reaches the register port with one-cycle strobes.
`timescale 1ns/1ps
module esc_host_model (
   input wire logic clock,
   output esc_pkg::esc_reg_req_t reg_req,
   input wire logic [7:0] reg_rdata
);
   initial reg_req = '0;

   // Address is scrambled after each access and write data after each write,
   // so that nothing can lean on a stale value lingering on the port.
   task wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_req.wr = 1'b1;
      reg_req.addr = a;
      reg_req.wdata = d;
      @(negedge clock);
      reg_req.wr = 1'b0;
      reg_req.addr = ~a;
      reg_req.wdata = ~d;
   endtask : wr

   task rd(input logic [6:0] a, output logic [7:0] d);
      @(negedge clock);
      reg_req.rd = 1'b1;
      reg_req.addr = a;
      @(negedge clock);
      reg_req.rd = 1'b0;
      reg_req.addr = ~a;
      d = reg_rdata;
   endtask : rd

   // Only the bits last seen set are cleared, so a fresh event survives.
   task clr(input logic [6:0] a);
      logic [7:0] d;
      rd(a, d);
      if (d != 8'h00)
      begin
         wr(a, d);
      end
   endtask : clr
endmodule : esc_host_model

/* verif/esc_event_regs_bench.sv */
// Self-checking bench for the event status and capture enable registers.
`timescale 1ns/1ps
module esc_event_regs_bench;
   localparam logic [6:0] A_EN = esc_pkg::ESC_ADDR_SYS_EN;
   localparam logic [6:0] A_GL = esc_pkg::ESC_ADDR_GLOBAL;
   localparam logic [6:0] A_SYS = esc_pkg::ESC_ADDR_SYS;
   localparam logic [6:0] A_SUP = esc_pkg::ESC_ADDR_SUP;
   localparam logic [6:0] A_TRX = esc_pkg::ESC_ADDR_TRX;
   localparam logic [6:0] A_WK = esc_pkg::ESC_ADDR_WAKE;
   localparam logic [7:0] TV [6] = '{8'h01, 8'h02, 8'h10, 8'h01, 8'h02,
      8'h04};
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic ce = 1'b1;
   esc_pkg::esc_reg_req_t reg_req;
   logic [7:0] reg_rdata;
   esc_pkg::esc_evt_t evt = '0;
   esc_pkg::esc_cap_en_t cap_en = '1;
   logic local_input = 1'b0;
   logic bus_active = 1'b0;
   logic offline = 1'b1;
   logic supply_on = 1'b1;
   logic reset_pin_low = 1'b0;
   logic event_pending;
   logic rxd;
   int errors = 0;
   int n_tests = 0;

   always #5 clock = ~clock;

   esc_host_model i_host (
      .clock(clock),
      .reg_req(reg_req),
      .reg_rdata(reg_rdata)
   );

   esc_event_regs #(.HAS_SENSOR_SUPPLY(1'b1), .DELAY_CYC(8)) i_dut (
      .clock(clock),
      .rst_b(rst_b),
      .ce(ce),
      .reg_req(reg_req),
      .reg_rdata(reg_rdata),
      .evt(evt),
      .cap_en(cap_en),
      .local_input(local_input),
      .bus_active(bus_active),
      .transceiver_offline(offline),
      .controller_supply_on(supply_on),
      .reset_pin_low(reset_pin_low),
      .event_pending(event_pending),
      .rxd(rxd)
   );

   task print_verdict;
      $display("comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict

   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e)
      begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask : chk

   task rchk(input logic [6:0] a, input logic [7:0] e);
      logic [7:0] d;
      i_host.rd(a, d);
      chk($sformatf("register %h", a), e, d);
   endtask : rchk

   task pulse(input esc_pkg::esc_evt_t e);
      @(negedge clock);
      evt = e;
      @(negedge clock);
      evt = '0;
   endtask : pulse

   task t_reset;
      logic [6:0] al [7];
      al = '{A_EN, A_GL, A_SYS, A_SUP, A_TRX, A_WK, 7'h10};
      chk("rxd", 8'h01, {7'h00, rxd});
      chk("event_pending", 8'h00, {7'h00, event_pending});
      foreach (al[i])
         rchk(al[i], 8'h00);
   endtask : t_reset

   task t_always;
      pulse(10'h240);
      rchk(A_SYS, 8'h11);
      rchk(A_GL, 8'h01);
      i_host.wr(A_SYS, 8'h00);
      rchk(A_SYS, 8'h11);
      i_host.wr(A_SYS, 8'h01);
      rchk(A_SYS, 8'h10);
      i_host.wr(A_SYS, 8'hff);
      rchk(A_SYS, 8'h00);
      rchk(A_GL, 8'h00);
   endtask : t_always

   task t_enable;
      pulse(10'h180);
      rchk(A_SYS, 8'h00);
      i_host.wr(A_EN, 8'hff);
      rchk(A_EN, 8'h06);
      pulse(10'h180);
      rchk(A_SYS, 8'h06);
      i_host.wr(A_GL, 8'hff);
      rchk(A_GL, 8'h01);
      i_host.clr(A_SYS);
      i_host.wr(A_EN, 8'h04);
      pulse(10'h180);
      rchk(A_SYS, 8'h04);
      i_host.clr(A_SYS);
      i_host.wr(A_EN, 8'h00);
   endtask : t_enable

   task t_table;
      for (int k = 0; k < 6; k++)
      begin
         pulse(10'h001 << k);
         rchk(k < 3 ? A_TRX : A_SUP, TV[k]);
         rchk(A_GL, k < 3 ? 8'h04 : 8'h02);
         i_host.clr(k < 3 ? A_TRX : A_SUP);
      end
      cap_en = '0;
      pulse(10'h03f);
      rchk(A_SUP, 8'h00);
      rchk(A_TRX, 8'h00);
      cap_en = '1;
      pulse(10'h004);
      bus_active = 1'b1;
      @(negedge clock);
      bus_active = 1'b0;
      rchk(A_TRX, 8'h00);
   endtask : t_table

   task t_wake;
      local_input = 1'b1;
      repeat (3) @(negedge clock);
      rchk(A_WK, 8'h02);
      rchk(A_GL, 8'h08);
      local_input = 1'b0;
      repeat (3) @(negedge clock);
      rchk(A_WK, 8'h03);
      i_host.clr(A_WK);
   endtask : t_wake

   task t_rxd;
      pulse(10'h240);
      repeat (12) @(negedge clock);
      chk("rxd", 8'h00, {7'h00, rxd});
      i_host.wr(A_SYS, 8'h01);
      @(negedge clock);
      chk("rxd", 8'h01, {7'h00, rxd});
      for (int i = 0; i < 20 && rxd !== 1'b0; i++)
         @(negedge clock);
      chk("rxd", 8'h00, {7'h00, rxd});
      supply_on = 1'b0;
      repeat (2) @(negedge clock);
      chk("rxd", 8'h01, {7'h00, rxd});
      supply_on = 1'b1;
      i_host.clr(A_SYS);
      repeat (15) @(negedge clock);
      chk("rxd", 8'h01, {7'h00, rxd});
   endtask : t_rxd

   // The clear and the new event land on the same edge on purpose.
   task t_collide;
      pulse(10'h040);
      fork
         i_host.wr(A_SYS, 8'h01);
         pulse(10'h040);
      join
      rchk(A_SYS, 8'h01);
      i_host.clr(A_SYS);
   endtask : t_collide

   // Waits out the delay timer left running by the previous clear first.
   task t_offline;
      repeat (10) @(negedge clock);
      offline = 1'b0;
      pulse(10'h241);
      repeat (2) @(negedge clock);
      chk("rxd", 8'h01, {7'h00, rxd});
      chk("event_pending", 8'h01, {7'h00, event_pending});
      rchk(A_TRX, 8'h00);
      offline = 1'b1;
      repeat (2) @(negedge clock);
      chk("rxd", 8'h00, {7'h00, rxd});
      i_host.wr(A_SYS, 8'h01);
      chk("rxd", 8'h01, {7'h00, rxd});
      reset_pin_low = 1'b1;
      @(negedge clock);
      chk("rxd", 8'h00, {7'h00, rxd});
      reset_pin_low = 1'b0;
      i_host.clr(A_SYS);
   endtask : t_offline

   task t_freeze;
      ce = 1'b0;
      pulse(10'h240);
      ce = 1'b1;
      rchk(A_SYS, 8'h00);
      chk("event_pending", 8'h00, {7'h00, event_pending});
   endtask : t_freeze

   initial
   begin
      repeat (10) @(negedge clock);
      rst_b = 1'b1;
      t_reset;
      t_always;
      t_enable;
      t_table;
      t_wake;
      t_rxd;
      t_collide;
      t_offline;
      t_freeze;
      print_verdict;
   end

   initial
   begin
      repeat (5000) @(posedge clock);
      errors++;
      print_verdict;
   end
endmodule : esc_event_regs_bench
